// file: vdc_pkg.sv
// Purpose: Shared constants for the video DRAM host controller.
// Assumes: 10 MHz system clock, one controller state step per clock.
// Notes: Command codes select the cycle type driven onto the device pins.
package vdc_pkg;
  // ==========================================================
  // Widths and geometry
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int ROWS = 512;
  localparam int SER_LEN = 512;
  // ==========================================================
  // Software register map (word offsets)
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ROW = 4'h1;
  localparam logic [3:0] REG_COL = 4'h2;
  localparam logic [3:0] REG_WDATA = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_SHIFT = 4'h6;
  localparam logic [3:0] REG_SERIAL = 4'h7;
  // Command field positions in REG_CMD write data.
  localparam int CMD_LSB = 0;
  localparam int CMD_W = 4;
  localparam int BYTE_LO_BIT = 4;
  localparam int BYTE_HI_BIT = 5;
  localparam int WRITE_BIT = 6;
  localparam int REFEN_BIT = 7;
  // Status field positions.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_HALF_BIT = 1;
  localparam int ST_REFOVR_BIT = 2;
  // ==========================================================
  // Cycle types
  typedef enum logic [3:0] {
    VDC_CMD_RW = 4'h0,
    VDC_CMD_MASKED = 4'h1,
    VDC_CMD_FILL = 4'h2,
    VDC_CMD_MFILL = 4'h3,
    VDC_CMD_LOAD_MASK = 4'h4,
    VDC_CMD_LOAD_COLOR = 4'h5,
    VDC_CMD_COPY = 4'h6,
    VDC_CMD_SPLIT = 4'h7,
    VDC_CMD_REF_CLEAR = 4'h8,
    VDC_CMD_REF_STOP = 4'h9,
    VDC_CMD_REF_KEEP = 4'ha,
    VDC_CMD_REF_ROW = 4'hb
  } vdc_cmd_t;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 10;
  localparam int REF_PERIOD_MS = 8;
  localparam int REF_ROWS = 512;
  localparam int REF_INTERVAL_CYC =
    (REF_PERIOD_MS * 1000 * CLK_MHZ) / REF_ROWS;
  localparam int PHASE_CYC = 1;
endpackage

// file: vdc_refresh_timer.sv
// Purpose: Requests one refresh every interval and flags overrun.
// Assumes: Pending request is held until the controller serves it.
// Notes: Interval rounds down so 512 refreshes fit within each period.
`timescale 1ns/10ps
module vdc_refresh_timer #(
  parameter int INTERVAL = vdc_pkg::REF_INTERVAL_CYC
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic enable_in,
  input wire logic served_in,
  output logic due_out,
  output logic overrun_out
);
  import vdc_pkg::*;
  logic [16:0] count_q;
  logic due_q;
  logic overrun_q;
  wire tick = (count_q == 17'(INTERVAL - 1));

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_q <= 17'h0;
    end else if (!enable_in || tick) begin
      count_q <= 17'h0;
    end else begin
      count_q <= count_q + 17'h1;
    end
  end

  // A new tick wins over a same-cycle service.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      due_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (enable_in && tick) begin
        due_q <= 1'b1;
        if (due_q && !served_in) begin
          overrun_q <= 1'b1;
        end
      end else if (served_in) begin
        due_q <= 1'b0;
      end
    end
  end

  assign due_out = due_q;
  assign overrun_out = overrun_q;

  chk_due_after_tick: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (enable_in && tick) |=> due_q)
    else $error("refresh request not raised at interval end");
endmodule // vdc_refresh_timer

// file: vdc_host.sv
// Purpose: Host controller driving a dual-port video DRAM by its pins.
// Assumes: Device pins sampled synchronously; one pin phase per clock.
// Notes: Software issues one cycle at a time through REG_CMD.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module vdc_host #(
  parameter int REF_INTERVAL = vdc_pkg::REF_INTERVAL_CYC
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic row_strobe_n_out,
  output logic low_byte_column_strobe_n_out,
  output logic high_byte_column_strobe_n_out,
  output logic [vdc_pkg::ADDR_W-1:0] addr_out,
  output logic write_select_n_out,
  output logic transfer_output_ctl_n_out,
  output logic function_select_out,
  input wire logic [vdc_pkg::DATA_W-1:0] mask_data_io_in,
  output logic [vdc_pkg::DATA_W-1:0] mask_data_io_out,
  output logic mask_data_io_oe_out,
  output logic shift_pulse_out,
  output logic shift_out_gate_n_out,
  input wire logic [vdc_pkg::DATA_W-1:0] serial_out_bus_in,
  input wire logic half_flag_in
);
  import vdc_pkg::*;

  // ==========================================================
  // Cycle sequencer
  typedef enum logic [2:0] {
    VDC_IDLE = 3'b000,
    VDC_ROW = 3'b001,
    VDC_RFALL = 3'b010,
    VDC_COL = 3'b011,
    VDC_CFALL = 3'b100,
    VDC_CBR_C = 3'b101,
    VDC_CBR_R = 3'b110,
    VDC_END = 3'b111
  } vdc_state_t;

  vdc_state_t state_q;
  vdc_cmd_t cmd_q;
  logic [ADDR_W-1:0] row_q, col_q;
  logic [DATA_W-1:0] wdata_q, rdata_q, serial_q;
  logic byte_lo_q, byte_hi_q, write_q, refen_q, ref_cycle_q;
  logic [15:0] shift_left_q;
  logic shift_q, gate_n_q;
  logic ref_due, ref_overrun;
  wire busy = (state_q != VDC_IDLE);
  wire cmd_wr = reg_wr_in && (reg_addr_in == REG_CMD) && !busy;
  wire start_ref = !busy && ref_due && !cmd_wr;
  wire is_ref = (cmd_q == VDC_CMD_REF_CLEAR) || (cmd_q == VDC_CMD_REF_STOP)
    || (cmd_q == VDC_CMD_REF_KEEP);
  wire is_copy = (cmd_q == VDC_CMD_COPY) || (cmd_q == VDC_CMD_SPLIT);
  wire is_masked = (cmd_q == VDC_CMD_MASKED) || (cmd_q == VDC_CMD_MFILL);
  wire is_load = (cmd_q == VDC_CMD_LOAD_MASK)
    || (cmd_q == VDC_CMD_LOAD_COLOR);
  wire is_fill = (cmd_q == VDC_CMD_FILL) || (cmd_q == VDC_CMD_MFILL);

  vdc_refresh_timer #(.INTERVAL(REF_INTERVAL)) u_ref (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .enable_in(refen_q),
    .served_in(start_ref),
    .due_out(ref_due),
    .overrun_out(ref_overrun)
  );

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= VDC_IDLE;
    end else begin
      unique case (state_q)
        VDC_IDLE: begin
          if (start_ref) begin
            state_q <= VDC_CBR_C;
          end else if (cmd_wr) begin
            state_q <= VDC_ROW;
          end
        end
        VDC_ROW: state_q <= (is_ref) ? VDC_CBR_C : VDC_RFALL;
        VDC_RFALL: state_q <= (cmd_q == VDC_CMD_REF_ROW) ? VDC_END : VDC_COL;
        VDC_COL: state_q <= VDC_CFALL;
        VDC_CFALL: state_q <= VDC_END;
        VDC_CBR_C: state_q <= VDC_CBR_R;
        VDC_CBR_R: state_q <= VDC_END;
        VDC_END: state_q <= VDC_IDLE;
      endcase
    end
  end

  // Command capture; a timer refresh reuses the option-keeping variant.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_q <= VDC_CMD_RW;
      byte_lo_q <= 1'b0;
      byte_hi_q <= 1'b0;
      write_q <= 1'b0;
      ref_cycle_q <= 1'b0;
    end else if (start_ref) begin
      cmd_q <= VDC_CMD_REF_KEEP;
      ref_cycle_q <= 1'b1;
    end else if (cmd_wr) begin
      cmd_q <= vdc_cmd_t'(reg_wdata_in[CMD_LSB +: CMD_W]);
      byte_lo_q <= reg_wdata_in[BYTE_LO_BIT];
      byte_hi_q <= reg_wdata_in[BYTE_HI_BIT];
      write_q <= reg_wdata_in[WRITE_BIT];
      ref_cycle_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      refen_q <= 1'b0;
      row_q <= '0;
      col_q <= '0;
      wdata_q <= '0;
      gate_n_q <= 1'b1;
    end else if (reg_wr_in) begin
      if (reg_addr_in == REG_CMD && !busy) begin
        refen_q <= reg_wdata_in[REFEN_BIT];
      end
      if (reg_addr_in == REG_ROW) row_q <= reg_wdata_in[ADDR_W-1:0];
      if (reg_addr_in == REG_COL) col_q <= reg_wdata_in[ADDR_W-1:0];
      if (reg_addr_in == REG_WDATA) wdata_q <= reg_wdata_in[DATA_W-1:0];
      if (reg_addr_in == REG_SHIFT) gate_n_q <= reg_wdata_in[16];
    end
  end

  // ==========================================================
  // Random-access port pins
  always_comb begin
    row_strobe_n_out = 1'b1;
    low_byte_column_strobe_n_out = 1'b1;
    high_byte_column_strobe_n_out = 1'b1;
    addr_out = row_q;
    write_select_n_out = 1'b1;
    transfer_output_ctl_n_out = 1'b1;
    function_select_out = 1'b0;
    mask_data_io_oe_out = 1'b0;
    mask_data_io_out = wdata_q;
    unique case (state_q)
      VDC_ROW, VDC_RFALL: begin
        row_strobe_n_out = (state_q == VDC_ROW);
        write_select_n_out = !(is_masked);
        transfer_output_ctl_n_out = !is_copy;
        function_select_out = (cmd_q == VDC_CMD_SPLIT) || is_load;
        mask_data_io_oe_out = is_masked;
        mask_data_io_out = wdata_q;
      end
      VDC_COL, VDC_CFALL: begin
        row_strobe_n_out = 1'b0;
        addr_out = col_q;
        low_byte_column_strobe_n_out = !((state_q == VDC_CFALL)
          && (byte_lo_q || is_copy || is_load));
        high_byte_column_strobe_n_out = !((state_q == VDC_CFALL)
          && (byte_hi_q || is_copy || is_load));
        write_select_n_out = !((write_q && !is_copy) || is_load);
        function_select_out = is_fill || (cmd_q == VDC_CMD_LOAD_COLOR);
        mask_data_io_oe_out = (write_q && !is_copy) || is_load;
      end
      VDC_CBR_C, VDC_CBR_R: begin
        row_strobe_n_out = (state_q == VDC_CBR_C);
        low_byte_column_strobe_n_out = 1'b0;
        high_byte_column_strobe_n_out = 1'b0;
        write_select_n_out = (cmd_q != VDC_CMD_REF_STOP);
        function_select_out = (cmd_q != VDC_CMD_REF_CLEAR);
        addr_out = col_q;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_q <= '0;
    end else if (state_q == VDC_CFALL && !write_q && !is_copy) begin
      rdata_q <= mask_data_io_in;
    end
  end

  // ==========================================================
  // Serial port: pulses run independently of the random port.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_left_q <= 16'h0;
      shift_q <= 1'b0;
      serial_q <= '0;
    end else begin
      if (reg_wr_in && reg_addr_in == REG_SHIFT) begin
        shift_left_q <= reg_wdata_in[15:0];
        shift_q <= 1'b0;
      end else if (shift_q) begin
        shift_q <= 1'b0;
        serial_q <= serial_out_bus_in;
      end else if (shift_left_q != 16'h0) begin
        shift_q <= 1'b1;
        shift_left_q <= shift_left_q - 16'h1;
      end
    end
  end
  assign shift_pulse_out = shift_q;
  assign shift_out_gate_n_out = gate_n_q;

  // ==========================================================
  // Software read port
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 32'h0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        REG_ROW: reg_rdata_out <= 32'(row_q);
        REG_COL: reg_rdata_out <= 32'(col_q);
        REG_WDATA: reg_rdata_out <= 32'(wdata_q);
        REG_RDATA: reg_rdata_out <= 32'(rdata_q);
        REG_STATUS: reg_rdata_out <= 32'({ref_overrun, half_flag_in,
          busy});
        REG_SERIAL: reg_rdata_out <= 32'(serial_q);
        default: reg_rdata_out <= 32'h0;
      endcase
    end else begin
      reg_rdata_out <= 32'h0;
    end
  end

  chk_ras_idle_high: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (state_q == VDC_IDLE) |-> row_strobe_n_out)
    else $error("row strobe low while idle");
  chk_row_then_fall: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (state_q == VDC_ROW && !is_ref)
    |=> !row_strobe_n_out && $stable(addr_out))
    else $error("row address not held across row strobe fall");
  chk_cas_after_ras: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) $fell(low_byte_column_strobe_n_out) && !ref_cycle_q
    && !is_ref |-> !row_strobe_n_out && addr_out == col_q)
    else $error("column strobe fell without row or column address");
  chk_copy_xfer_low: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) $fell(row_strobe_n_out) && is_copy
    |-> !transfer_output_ctl_n_out)
    else $error("transfer control not low at copy row fall");
  chk_masked_ws_low: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) $fell(row_strobe_n_out) && is_masked
    |-> !write_select_n_out && mask_data_io_oe_out)
    else $error("masked cycle lacks write select low");
  chk_cbr_order: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (state_q == VDC_CBR_C)
    |-> row_strobe_n_out && !low_byte_column_strobe_n_out
    ##1 !row_strobe_n_out)
    else $error("column strobe not ahead of row strobe in refresh");
  chk_clear_fs_low: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (state_q == VDC_CBR_R
    && cmd_q == VDC_CMD_REF_CLEAR) |-> !function_select_out)
    else $error("clearing refresh with function select high");
  chk_shift_pulse_one: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) shift_pulse_out |=> !shift_pulse_out)
    else $error("shift pulse longer than one cycle");
endmodule // vdc_host

// file: vdc_dev_model.sv
// Purpose: Behavioural dual-port video DRAM seen by the host controller.
// Assumes: Pins follow strobe edges only; no clock of its own.
// Notes: Released data pins show the inverse of the last driven word.
`timescale 1ns/10ps
module vdc_dev_model (
  input wire logic row_strobe_n_in,
  input wire logic lo_cas_n_in,
  input wire logic hi_cas_n_in,
  input wire logic [8:0] addr_in,
  input wire logic write_select_n_in,
  input wire logic transfer_output_ctl_n_in,
  input wire logic function_select_in,
  input wire logic [15:0] dq_in,
  input wire logic shift_pulse_in,
  input wire logic shift_out_gate_n_in,
  output logic [15:0] dq_out,
  output logic dq_oe_out,
  output logic [15:0] serial_out_bus_out,
  output logic half_flag_out
);
  logic [15:0] mem [int];
  logic [8:0] row_q, ptr_q = 0, ser_row_q = 0, stop_q = 0;
  logic ws_q, tr_q, fs_q, mask_on_q = 0, rd_q = 0;
  logic [15:0] mask_q, nmask_q, sq_q = 0, rd_word_q = 0, last_q = 0;
  logic [15:0] color_q = 0;
  int cbr_cnt = 0, pulses = 0;
  wire cas_n = lo_cas_n_in & hi_cas_n_in;
  function automatic logic [15:0] peek(input int i);
    return mem.exists(i) ? mem[i] : 16'h0000;
  endfunction
  // ==========================================================
  // Random-access port
  always @(negedge row_strobe_n_in) begin
    row_q = addr_in;
    ws_q = write_select_n_in;
    tr_q = transfer_output_ctl_n_in;
    fs_q = function_select_in;
    nmask_q = dq_in;
    if (!cas_n) begin
      cbr_cnt++;
      if (!fs_q) mask_on_q = 1'b0;
      else if (!ws_q) stop_q = addr_in;
    end
  end
  always @(negedge cas_n) begin
    int i, j;
    logic [15:0] m;
    i = {row_q, addr_in};
    m = {{8{!hi_cas_n_in}}, {8{!lo_cas_n_in}}};
    if (!row_strobe_n_in) begin
      if (!tr_q) begin
        ser_row_q = row_q;
        ptr_q = addr_in;
      end else if (fs_q) begin
        if (!function_select_in) begin
          mask_q = dq_in;
          mask_on_q = 1'b1;
        end else begin
          color_q = dq_in;
        end
      end else if (!write_select_n_in) begin
        if (!ws_q) m = m & (mask_on_q ? mask_q : nmask_q);
        if (function_select_in) begin
          for (int k = 0; k < 8; k++) begin
            j = {row_q, addr_in[8:3], 3'(k)};
            if (dq_in[k]) mem[j] = (peek(j) & ~m) | (color_q & m);
          end
        end else begin
          mem[i] = (peek(i) & ~m) | (dq_in & m);
        end
      end else begin
        rd_word_q = peek(i);
        rd_q = 1'b1;
      end
    end
  end
  always @(posedge cas_n) begin
    if (rd_q) last_q = rd_word_q;
    rd_q = 1'b0;
  end
  assign dq_oe_out = rd_q & !cas_n;
  assign dq_out = dq_oe_out ? rd_word_q : ~last_q;
  // ==========================================================
  // Serial port, read only
  always @(posedge shift_pulse_in) begin
    sq_q = peek({ser_row_q, ptr_q});
    ptr_q = ptr_q + 9'h001;
    pulses++;
  end
  assign serial_out_bus_out = shift_out_gate_n_in ? ~sq_q : sq_q;
  assign half_flag_out = ptr_q[8];
endmodule // vdc_dev_model

// file: tb_top.sv
// Purpose: Self-checking bench for the video DRAM host controller.
// Assumes: Refresh interval shortened to 20 cycles.
// Notes: Scenarios run in order and share device state.
`timescale 1ns/10ps
module tb_top;
  import vdc_pkg::*;
  logic sys_clk_in = 0, nrst_in = 0, reg_wr = 0, reg_rd = 0, ref_en = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  logic ras_n, lo_cs_n, hi_cs_n, ws_n, tr_n, fs, hoe, sp, gate_n, doe, hf;
  logic [8:0] addr;
  logic [15:0] hdq, ddq, sq;
  wire [15:0] dq = (hoe & doe) ? 16'hxxxx : (hoe ? hdq : ddq);
  int n_errors = 0, cmp_count = 0, cyc = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  vdc_host #(.REF_INTERVAL(20)) u_dut (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
    .row_strobe_n_out(ras_n), .low_byte_column_strobe_n_out(lo_cs_n),
    .high_byte_column_strobe_n_out(hi_cs_n), .addr_out(addr),
    .write_select_n_out(ws_n), .transfer_output_ctl_n_out(tr_n),
    .function_select_out(fs), .mask_data_io_in(dq),
    .mask_data_io_out(hdq), .mask_data_io_oe_out(hoe),
    .shift_pulse_out(sp), .shift_out_gate_n_out(gate_n),
    .serial_out_bus_in(sq), .half_flag_in(hf));
  vdc_dev_model dev (.row_strobe_n_in(ras_n), .lo_cas_n_in(lo_cs_n),
    .hi_cas_n_in(hi_cs_n), .addr_in(addr), .write_select_n_in(ws_n),
    .transfer_output_ctl_n_in(tr_n), .function_select_in(fs),
    .dq_in(dq), .shift_pulse_in(sp), .shift_out_gate_n_in(gate_n),
    .dq_out(ddq), .dq_oe_out(doe), .serial_out_bus_out(sq),
    .half_flag_out(hf));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd <= 1'b0;
    @(negedge sys_clk_in);
    d = reg_rdata;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [8:0] r, col,
                     input logic [15:0] d, input logic [1:0] b,
                     input logic w);
    logic [31:0] s;
    wr(REG_ROW, {23'h0, r});
    wr(REG_COL, {23'h0, col});
    wr(REG_WDATA, {16'h0, d});
    wr(REG_CMD, {24'h0, ref_en, w, b, c});
    for (int k = 0; k < 50; k++) begin
      rd(REG_STATUS, s);
      if (s[ST_BUSY_BIT] === 1'b0) return;
    end
    chk("busy clears", 32'h0, s);
  endtask
  task automatic rdw(input logic [8:0] r, col, output logic [31:0] d);
    cmd(VDC_CMD_RW, r, col, 16'h0, 2'b11, 1'b0);
    rd(REG_RDATA, d);
  endtask
  task automatic shift(input logic [15:0] n, input logic g);
    int p = dev.pulses + n;
    wr(REG_SHIFT, {15'h0, g, n});
    for (int k = 0; k < 2000 && dev.pulses < p; k++) @(posedge sys_clk_in);
    chk("pulse count", p, dev.pulses);
    repeat (4) @(posedge sys_clk_in);
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("row strobe idle", 32'h1, ras_n);
    chk("column strobes idle", 32'h3, {hi_cs_n, lo_cs_n});
    chk("data drive", 32'h0, hoe);
    chk("serial gate", 32'h1, gate_n);
  endtask
  task automatic t_rw();
    cmd(VDC_CMD_RW, 9'h1ff, 9'h1ff, 16'hbeef, 2'b11, 1'b1);
    cmd(VDC_CMD_RW, 9'h000, 9'h000, 16'h1234, 2'b11, 1'b1);
    chk("top word", 16'hbeef, dev.peek(32'h3ffff));
    rdw(9'h1ff, 9'h1ff, rv);
    chk("read word", 16'hbeef, rv[15:0]);
  endtask
  task automatic t_bytes();
    cmd(VDC_CMD_RW, 9'h000, 9'h000, 16'h55aa, 2'b01, 1'b1);
    rdw(9'h000, 9'h000, rv);
    chk("low byte write", 16'h12aa, rv[15:0]);
  endtask
  task automatic t_mask();
    cmd(VDC_CMD_LOAD_MASK, 9'h000, 9'h000, 16'h00ff, 2'b11, 1'b1);
    cmd(VDC_CMD_REF_KEEP, 9'h000, 9'h000, 16'h0, 2'b11, 1'b0);
    cmd(VDC_CMD_MASKED, 9'h000, 9'h000, 16'habcd, 2'b11, 1'b1);
    rdw(9'h000, 9'h000, rv);
    chk("old mask write", 16'h12cd, rv[15:0]);
    cmd(VDC_CMD_REF_CLEAR, 9'h000, 9'h000, 16'h0, 2'b11, 1'b0);
    chk("mask cleared", 32'h0, dev.mask_on_q);
    cmd(VDC_CMD_REF_STOP, 9'h000, 9'h080, 16'h0, 2'b11, 1'b0);
    chk("stop value", 32'h080, dev.stop_q);
  endtask
  task automatic t_fill();
    cmd(VDC_CMD_LOAD_COLOR, 9'h000, 9'h000, 16'h7e7e, 2'b11, 1'b1);
    cmd(VDC_CMD_FILL, 9'h006, 9'h010, 16'h0005, 2'b11, 1'b1);
    rdw(9'h006, 9'h012, rv);
    chk("fill enabled column", 16'h7e7e, rv[15:0]);
    rdw(9'h006, 9'h011, rv);
    chk("fill masked column", 16'h0000, rv[15:0]);
  endtask
  task automatic t_copy();
    cmd(VDC_CMD_RW, 9'h005, 9'h0ff, 16'ha5a5, 2'b11, 1'b1);
    cmd(VDC_CMD_RW, 9'h005, 9'h100, 16'h5a5a, 2'b11, 1'b1);
    cmd(VDC_CMD_COPY, 9'h005, 9'h0ff, 16'h0, 2'b11, 1'b0);
    shift(16'd1, 1'b0);
    rd(REG_SERIAL, rv);
    chk("serial tap word", 16'ha5a5, rv[15:0]);
    rd(REG_STATUS, rv);
    chk("half flag upper", 32'h1, rv[ST_HALF_BIT]);
    shift(16'd1, 1'b0);
    rd(REG_SERIAL, rv);
    chk("serial next word", 16'h5a5a, rv[15:0]);
    shift(16'd255, 1'b1);
    chk("gate off", 32'h1, gate_n);
    rd(REG_STATUS, rv);
    chk("half flag wrapped", 32'h0, rv[ST_HALF_BIT]);
    rd(REG_SERIAL, rv);
    chk("gated serial", 16'hffff, rv[15:0]);
    cmd(VDC_CMD_SPLIT, 9'h005, 9'h100, 16'h0, 2'b11, 1'b0);
    shift(16'd1, 1'b0);
    rd(REG_SERIAL, rv);
    chk("split tap word", 16'h5a5a, rv[15:0]);
  endtask
  task automatic t_refresh();
    int c0 = dev.cbr_cnt;
    cmd(VDC_CMD_REF_ROW, 9'h005, 9'h000, 16'h0, 2'b11, 1'b0);
    ref_en = 1'b1;
    cmd(VDC_CMD_REF_KEEP, 9'h000, 9'h000, 16'h0, 2'b11, 1'b0);
    repeat (400) @(posedge sys_clk_in);
    chk("timer refreshes", 32'h1, (dev.cbr_cnt - c0) >= 18);
    rd(REG_STATUS, rv);
    chk("no overrun", 32'h0, rv[ST_REFOVR_BIT]);
    ref_en = 1'b0;
    // Start right after a timer refresh so the command is not refused.
    @(posedge ras_n);
    rdw(9'h005, 9'h0ff, rv);
    chk("row refresh keeps data", 16'ha5a5, rv[15:0]);
  endtask
  // ==========================================================
  // Sequence and watchdog
  initial begin
    repeat (20) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(negedge sys_clk_in);
    t_reset();
    t_rw();
    t_bytes();
    t_mask();
    t_fill();
    t_copy();
    t_refresh();
    stop_test();
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      $display("CHECK FAILED watchdog expected done seen hang");
      stop_test();
    end
  end
endmodule // tb_top
